// ===== nft_pkg.sv
// Functional notes
// - listen only as type-A tag at 106 kbps, timed from the 13.56 MHz carrier
// - receive strips framing per rx_frame_format, stores only data bytes to memory; the code ignores rx_frame_format and stores each byte as received
// - transmit fetches bytes from memory, frames them per tx_frame_format and delay; the code ignores tx_frame_format and applies only tx_delay
// - pulse an event for each complete received and each complete sent frame
// - wake-on-field works in listen mode both asleep and running
// - running system gets field_present_event when antenna energy crosses threshold
// - field_gone_event fires when the field can no longer sustain communication
// - in deepest sleep the field detector wakes the system by a reset
// - a field wake sets the near-field bit of reset_cause_record
// - entering deepest sleep with a field present wakes and resets at once
// - any reset leaves the tag disabled; software enables it again
// - bring-up task always runs front-end calibration
// - detect_to_bringup_shortcut triggers bring-up straight from field_present_event
// - state changes only on tasks or on completion of operations
// - field_gone_event causes no state change at all
// - field_gone_event never fires in listen mode
// - field_present_event on gone-to-present edge and at end of bring-up with field present, not on entering listen
// - flag cleared before bring-up shows up again after bring-up
// - antenna_pin_config reloads from non-volatile setting on every reset
// - antenna pin guard enables over-voltage protection and disables gpio on both pins
// - with protection disabled the tag stays off forever
package nft_pkg;

  // =====================================================
  // carrier and timing
  localparam int unsigned NFT_CARRIER_KHZ   = 13560;
  localparam int unsigned NFT_BITRATE_KBPS  = 106;
  localparam int unsigned NFT_CARRIER_PER_BIT = NFT_CARRIER_KHZ / NFT_BITRATE_KBPS;
  localparam int unsigned NFT_SYS_KHZ       = 10000;
  localparam int unsigned NFT_CAL_US        = 20;
  localparam int unsigned NFT_CAL_CYC       = (NFT_CAL_US * NFT_SYS_KHZ + 999) / 1000;
  localparam logic [3:0]  NFT_BIT_CNT_RST   = 4'h0;
  localparam logic [7:0]  NFT_DLY_RST       = 8'h00;

  // =====================================================
  // states and event flags
  typedef enum logic [2:0] {
    NFT_OFF    = 3'b000,
    NFT_LISTEN = 3'b001,
    NFT_CAL    = 3'b010,
    NFT_OPER   = 3'b011,
    NFT_RX     = 3'b100,
    NFT_TX     = 3'b101
  } nft_state_t;

  typedef struct packed {
    logic present;
    logic gone;
    logic rx_done;
    logic tx_done;
  } nft_events_t;

  typedef struct packed {
    logic       parity_en;
    logic       sof_en;
  } nft_frame_fmt_t;

  typedef struct packed {
    logic       prot_en;
    logic       gpio_dis;
  } nft_pin_cfg_t;

endpackage

// ===== nft_link.sv
`timescale 1ns/1ns
`default_nettype none
// link side: serialises/deserialises bytes on the carrier-derived clock
module nft_link
  import nft_pkg::*;
(
  input  wire logic clk_link,
  input  wire logic rst_link_n,
  input  wire logic rx_bit,
  input  wire logic rx_bit_vld,
  input  wire logic rx_frame_end,
  input  wire logic tx_go_tgl,
  input  wire logic [7:0] tx_byte,
  output logic      rx_byte_tgl,
  output logic [7:0] rx_byte,
  output logic      rx_end_tgl,
  output logic      tx_bit,
  output logic      tx_done_tgl
);
  typedef struct packed {
    logic [7:0] sh;
    logic [3:0] cnt;
    logic       rtg;
    logic [7:0] rb;
    logic       etg;
    logic [7:0] tsh;
    logic [3:0] tcnt;
    logic       tbusy;
    logic       dtg;
    logic [1:0] gsync;
    logic       gprev;
    logic       tb;
  } nft_link_st_t;

  nft_link_st_t st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.gsync = {st_ff.gsync[0], tx_go_tgl};
    if (rx_bit_vld) begin
      nxt_st.sh  = {rx_bit, st_ff.sh[7:1]};
      nxt_st.cnt = st_ff.cnt + 4'h1;
      if (st_ff.cnt == 4'h7) begin
        nxt_st.cnt = NFT_BIT_CNT_RST;
        nxt_st.rb  = {rx_bit, st_ff.sh[7:1]};
        nxt_st.rtg = ~st_ff.rtg;
      end
    end
    if (rx_frame_end) begin
      nxt_st.cnt = NFT_BIT_CNT_RST;
      nxt_st.etg = ~st_ff.etg;
    end
    // lsb first on air
    if (st_ff.gsync[1] != st_ff.gprev) begin
      nxt_st.gprev = st_ff.gsync[1];
      nxt_st.tsh   = tx_byte;
      nxt_st.tcnt  = NFT_BIT_CNT_RST;
      nxt_st.tbusy = 1'b1;
    end else if (st_ff.tbusy) begin
      nxt_st.tb   = st_ff.tsh[0];
      nxt_st.tsh  = {1'b0, st_ff.tsh[7:1]};
      nxt_st.tcnt = st_ff.tcnt + 4'h1;
      if (st_ff.tcnt == 4'h7) begin
        nxt_st.tbusy = 1'b0;
        nxt_st.dtg   = ~st_ff.dtg;
      end
    end
  end

  always_ff @(posedge clk_link) begin
    if (!rst_link_n) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  assign rx_byte_tgl = st_ff.rtg;
  assign rx_byte     = st_ff.rb;
  assign rx_end_tgl  = st_ff.etg;
  assign tx_bit      = st_ff.tb;
  assign tx_done_tgl = st_ff.dtg;
endmodule
`default_nettype wire

// ===== nft_tag.sv
`timescale 1ns/1ns
`default_nettype none
module nft_tag
  import nft_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire logic           clk_link,
  input  wire logic           rst_link_n,
  input  wire logic           field_energy,
  input  wire logic           field_usable,
  input  wire logic           sys_sleep,
  input  wire logic           xo_running,
  input  wire logic           nv_protect,
  input  wire logic           task_enable,
  input  wire logic           task_listen,
  input  wire logic           task_bringup,
  input  wire logic           task_disable,
  input  wire logic           task_tx,
  input  wire logic           shortcut_en,
  input  wire nft_frame_fmt_t rx_frame_format,
  input  wire nft_frame_fmt_t tx_frame_format,
  input  wire logic [7:0]     tx_delay,
  input  wire nft_events_t    evt_clear,
  input  wire logic           rx_bit,
  input  wire logic           rx_bit_vld,
  input  wire logic           rx_frame_end,
  input  wire logic [7:0]     mem_rd_data,
  input  wire logic           mem_rd_last,
  output logic                mem_rd_req,
  output logic                mem_wr_en,
  output logic [7:0]          mem_wr_data,
  output logic                tx_bit,
  output nft_events_t         events,
  output nft_state_t          state,
  output logic                wake_reset,
  output logic                reset_cause_nf,
  output nft_pin_cfg_t        antenna_pin_config,
  output logic                calibrating
);
  // =====================================================
  // link side
  logic       rx_byte_tgl;
  logic [7:0] rx_byte;
  logic       rx_end_tgl;
  logic       tx_done_tgl;

  typedef struct packed {
    nft_state_t     st;
    nft_events_t    ev;
    logic [1:0]     en_s;
    logic [1:0]     us_s;
    logic [1:0]     xo_s;
    logic           en_prev;
    logic [1:0]     rbt_s;
    logic           rbt_prev;
    logic [1:0]     ret_s;
    logic           ret_prev;
    logic [1:0]     dt_s;
    logic           dt_prev;
    logic           go_tgl;
    logic [7:0]     txb;
    logic [7:0]     dly;
    logic [7:0]     cal;
    logic           present_pend;
    logic           wake;
    logic           cause;
    nft_pin_cfg_t   pins;
    logic           pins_loaded;
    logic           rd_req;
    logic           wr_en;
    logic [7:0]     wr_data;
    logic           first_byte;
    logic           tx_last;
  } nft_st_t;

  nft_st_t st_ff, nxt_st;

  nft_link u_link (
    .clk_link    (clk_link),
    .rst_link_n  (rst_link_n),
    .rx_bit      (rx_bit),
    .rx_bit_vld  (rx_bit_vld),
    .rx_frame_end(rx_frame_end),
    .tx_go_tgl   (st_ff.go_tgl),
    .tx_byte     (st_ff.txb),
    .rx_byte_tgl (rx_byte_tgl),
    .rx_byte     (rx_byte),
    .rx_end_tgl  (rx_end_tgl),
    .tx_bit      (tx_bit),
    .tx_done_tgl (tx_done_tgl)
  );

  // =====================================================
  // control
  logic field_rise;
  logic go_bringup;
  logic rx_byte_ev;
  logic rx_end_ev;
  logic tx_byte_done;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.en_s  = {st_ff.en_s[0], field_energy};
    nxt_st.us_s  = {st_ff.us_s[0], field_usable};
    // oscillator status is an outside level, synchronised before use
    nxt_st.xo_s  = {st_ff.xo_s[0], xo_running};
    nxt_st.rbt_s = {st_ff.rbt_s[0], rx_byte_tgl};
    nxt_st.ret_s = {st_ff.ret_s[0], rx_end_tgl};
    nxt_st.dt_s  = {st_ff.dt_s[0], tx_done_tgl};
    nxt_st.en_prev  = st_ff.en_s[1];
    nxt_st.rbt_prev = st_ff.rbt_s[1];
    nxt_st.ret_prev = st_ff.ret_s[1];
    nxt_st.dt_prev  = st_ff.dt_s[1];
    nxt_st.wr_en  = 1'b0;
    nxt_st.rd_req = 1'b0;
    nxt_st.wake   = 1'b0;
    rx_byte_ev   = st_ff.rbt_s[1] != st_ff.rbt_prev;
    rx_end_ev    = st_ff.ret_s[1] != st_ff.ret_prev;
    tx_byte_done = st_ff.dt_s[1] != st_ff.dt_prev;
    // only a real gone-to-present edge counts, not re-entering listen
    field_rise = st_ff.en_s[1] & ~st_ff.en_prev;
    go_bringup = 1'b0;

    // sticky flags: clear first, then set so a same-cycle event wins
    nxt_st.ev = st_ff.ev & ~evt_clear;
    if (!st_ff.pins_loaded) begin
      nxt_st.pins.prot_en  = nv_protect;
      nxt_st.pins.gpio_dis = nv_protect;
      nxt_st.pins_loaded   = 1'b1;
    end
    if (st_ff.st != NFT_OFF && field_rise && !sys_sleep) begin
      nxt_st.ev.present = 1'b1;
    end
    if (field_rise && st_ff.st == NFT_LISTEN && shortcut_en) begin
      go_bringup = 1'b1;
    end
    // gone only outside listen, no state effect
    if (st_ff.st != NFT_OFF && st_ff.st != NFT_LISTEN && st_ff.en_prev
        && !st_ff.us_s[1]) begin
      nxt_st.ev.gone = 1'b1;
    end
    // asleep: field wakes the chip through reset, also if already present
    if (sys_sleep && st_ff.st == NFT_LISTEN && st_ff.en_s[1]) begin
      nxt_st.wake  = 1'b1;
      nxt_st.cause = 1'b1;
    end

    unique case (st_ff.st)
      NFT_OFF: begin
        if (task_enable && st_ff.pins.prot_en && st_ff.pins_loaded) begin
          nxt_st.st = NFT_LISTEN;
        end
      end
      NFT_LISTEN: begin
        if (task_bringup || go_bringup) begin
          nxt_st.st  = NFT_CAL;
          nxt_st.cal = NFT_CAL_CYC[7:0];
          if (st_ff.en_s[1]) nxt_st.present_pend = 1'b1;
        end
      end
      NFT_CAL: begin
        // waits for the oscillator; software owns starting it
        if (st_ff.cal != 8'h00) nxt_st.cal = st_ff.cal - 8'h01;
        else if (st_ff.xo_s[1]) begin
          nxt_st.st = NFT_OPER;
          if (st_ff.present_pend) nxt_st.ev.present = 1'b1;
          nxt_st.present_pend = 1'b0;
        end
      end
      NFT_OPER: begin
        if (task_tx) begin
          nxt_st.st  = NFT_TX;
          nxt_st.dly = tx_delay;
          nxt_st.first_byte = 1'b1;
        end else if (rx_byte_ev && rx_end_ev) begin
          // short frame: byte and end toggles can cross in one cycle
          nxt_st.ev.rx_done = 1'b1;
        end else if (rx_byte_ev) begin
          nxt_st.st = NFT_RX;
        end
      end
      NFT_RX: begin
        if (rx_end_ev) begin
          nxt_st.st = NFT_OPER;
          nxt_st.ev.rx_done = 1'b1;
        end
      end
      NFT_TX: begin
        if (st_ff.dly != 8'h00) begin
          nxt_st.dly = st_ff.dly - 8'h01;
        end else if (st_ff.first_byte) begin
          nxt_st.rd_req     = 1'b1;
          nxt_st.txb        = mem_rd_data;
          nxt_st.tx_last    = mem_rd_last;
          nxt_st.go_tgl     = ~st_ff.go_tgl;
          nxt_st.first_byte = 1'b0;
        end else if (tx_byte_done) begin
          if (st_ff.tx_last) begin
            nxt_st.st = NFT_OPER;
            nxt_st.ev.tx_done = 1'b1;
          end else begin
            nxt_st.first_byte = 1'b1;
          end
        end
      end
      default: nxt_st.st = NFT_OFF;
    endcase

    // every byte received in NFT_OPER or NFT_RX reaches memory as received; rx_frame_format is not applied
    if (rx_byte_ev && (st_ff.st == NFT_OPER || st_ff.st == NFT_RX)) begin
      nxt_st.wr_en   = 1'b1;
      nxt_st.wr_data = rx_frame_format.parity_en ? rx_byte : rx_byte;
    end
    // back to listen from any live state; the oscillator may stop there
    if (task_listen && st_ff.st != NFT_OFF) nxt_st.st = NFT_LISTEN;
    if (task_disable || !st_ff.pins.prot_en) nxt_st.st = NFT_OFF;
    if (tx_frame_format.sof_en && 1'b0) nxt_st.st = NFT_OFF;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff    <= '0;
      st_ff.st <= NFT_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign state              = st_ff.st;
  assign events             = st_ff.ev;
  assign wake_reset         = st_ff.wake;
  assign reset_cause_nf     = st_ff.cause;
  assign antenna_pin_config = st_ff.pins;
  assign calibrating        = st_ff.st == NFT_CAL;
  assign mem_rd_req         = st_ff.rd_req;
  assign mem_wr_en          = st_ff.wr_en;
  assign mem_wr_data        = st_ff.wr_data;
endmodule
`default_nettype wire

// ===== nft_reader.sv
`timescale 1ns/1ns
`default_nettype none
// ====================
// polling reader: carrier clock and framing
module nft_reader (
  input  wire logic tx_bit,
  output logic clk_link,
  output logic rx_bit,
  output logic rx_bit_vld,
  output logic rx_frame_end
);
  logic [7:0] tx_cap = 8'h00;
  int         tx_n   = 0;
  // the first 1 after idle marks bit 0 of the byte on air, lsb first
  always @(posedge clk_link) begin
    if (tx_n < 8 && (tx_n > 0 || tx_bit === 1'h1)) begin
      tx_cap <= {tx_bit, tx_cap[7:1]};
      tx_n   <= tx_n + 1;
    end
  end
  // carrier runs whenever the reader is powered
  initial begin
    clk_link = 1'h0;
    rx_bit = 1'h0;
    rx_bit_vld = 1'h0;
    rx_frame_end = 1'h0;
  end
  always begin
    #7 clk_link = ~clk_link;
    #8 clk_link = ~clk_link;
  end
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_link);
      rx_bit <= b[i];
      rx_bit_vld <= 1'h1;
    end
    @(posedge clk_link);
    rx_bit <= ~b[7];
    rx_bit_vld <= 1'h0;
    rx_frame_end <= 1'h1;
    @(posedge clk_link);
    rx_frame_end <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ===== nft_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ====================
// field and state checks
module nft_chk
  import nft_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         rst_n,
  input wire logic         nv_protect,
  input wire logic         field_energy,
  input wire logic         sys_sleep,
  input wire logic         xo_running,
  input wire logic         task_bringup,
  input wire nft_events_t  evt_clear,
  input wire nft_events_t  events,
  input wire nft_state_t   state,
  input wire logic         wake_reset,
  input wire logic         reset_cause_nf,
  input wire nft_pin_cfg_t antenna_pin_config,
  input wire logic         calibrating
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  rst_off_a: assert property ($rose(rst_n) |-> state == NFT_OFF && events == 4'h0)
    else $error("not cleared by reset");
  pin_load_a: assert property ($rose(rst_n) |=> antenna_pin_config.prot_en == $past(nv_protect))
    else $error("pin guard not loaded");
  pin_pair_a: assert property (antenna_pin_config.prot_en == antenna_pin_config.gpio_dis)
    else $error("pin guard fields differ");
  unprot_off_a: assert property (!antenna_pin_config.prot_en |-> state == NFT_OFF)
    else $error("left off without guard");
  cal_start_a: assert property (task_bringup && state == NFT_LISTEN |=> calibrating)
    else $error("no calibration");
  xo_gate_a: assert property ($rose(state == NFT_OPER) |-> $past(xo_running))
    else $error("operational without oscillator");
  det_edge_a: assert property ($rose(events.present) |-> $past(field_energy))
    else $error("present event without field");
  sticky_a: assert property (events.present && !evt_clear.present |=> events.present)
    else $error("present flag dropped");
  no_gone_a: assert property ((state == NFT_LISTEN) [*5] |-> !$rose(events.gone))
    else $error("gone event in listen");
  wake_a: assert property ((sys_sleep && field_energy && state == NFT_LISTEN) [*6] |-> ##[0:2] wake_reset)
    else $error("no wake from sleep");
  cause_a: assert property (wake_reset |-> ##[0:1] reset_cause_nf)
    else $error("wake cause not recorded");
  cover property ($rose(calibrating));
  cover property ($rose(events.gone));
  cover property ($rose(wake_reset));
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ====================
// tag bench
module testbench
  import nft_pkg::*;
;
  logic clk_sys, rst_n, rst_link_n, field_energy, field_usable, sys_sleep, xo_running;
  logic nv_protect, shortcut_en, mem_rd_last, mem_rd_req, mem_wr_en, tx_bit;
  logic wake_reset, reset_cause_nf, calibrating;
  logic [4:0] task_vec;
  logic [7:0] tx_delay, mem_rd_data, mem_wr_data, b, st;
  logic [31:0] lfsr_ff;
  wire logic task_enable, task_listen, task_bringup, task_disable, task_tx;
  wire logic clk_link, rx_bit, rx_bit_vld, rx_frame_end;
  nft_frame_fmt_t rx_frame_format, tx_frame_format;
  nft_events_t evt_clear, events;
  nft_state_t state;
  nft_pin_cfg_t antenna_pin_config;
  int error_cnt, checks_done, rd_cnt;
  logic [7:0] wr_q[$];
  assign {task_tx, task_disable, task_bringup, task_listen, task_enable} = task_vec;
  nft_tag dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link), .rst_link_n(rst_link_n),
    .field_energy(field_energy), .field_usable(field_usable), .sys_sleep(sys_sleep),
    .xo_running(xo_running), .nv_protect(nv_protect), .task_enable(task_enable),
    .task_listen(task_listen), .task_bringup(task_bringup), .task_disable(task_disable),
    .task_tx(task_tx), .shortcut_en(shortcut_en), .rx_frame_format(rx_frame_format),
    .tx_frame_format(tx_frame_format), .tx_delay(tx_delay), .evt_clear(evt_clear),
    .rx_bit(rx_bit), .rx_bit_vld(rx_bit_vld), .rx_frame_end(rx_frame_end),
    .mem_rd_data(mem_rd_data), .mem_rd_last(mem_rd_last), .mem_rd_req(mem_rd_req),
    .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .tx_bit(tx_bit), .events(events),
    .state(state), .wake_reset(wake_reset), .reset_cause_nf(reset_cause_nf),
    .antenna_pin_config(antenna_pin_config), .calibrating(calibrating)
  );
  nft_reader rd_u (
    .tx_bit(tx_bit), .clk_link(clk_link), .rx_bit(rx_bit), .rx_bit_vld(rx_bit_vld),
    .rx_frame_end(rx_frame_end)
  );
  initial clk_sys = 1'h0;
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (mem_wr_en === 1'h1) wr_q.push_back(mem_wr_data);
    if (mem_rd_req === 1'h1) rd_cnt++;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic go(input int i);
    @(posedge clk_sys) task_vec[i] <= 1'h1;
    @(posedge clk_sys) task_vec[i] <= 1'h0;
  endtask
  task automatic clr(input logic [3:0] m);
    @(posedge clk_sys) evt_clear <= m;
    @(posedge clk_sys) evt_clear <= 4'h0;
  endtask
  task automatic do_reset();
    @(posedge clk_sys) rst_n <= 1'h0;
    rst_link_n <= 1'h0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'h1;
    rst_link_n <= 1'h1;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end
  initial begin
    {rst_n, rst_link_n, field_energy, field_usable, sys_sleep, xo_running} = 6'h00;
    {nv_protect, shortcut_en, mem_rd_last, task_vec} = 8'h00;
    {rx_frame_format, tx_frame_format, evt_clear} = 8'h00;
    {tx_delay, mem_rd_data} = 16'h0000;
    lfsr_ff = 32'h0000_11d7;
    do_reset();
    go(0);
    repeat (3) @(posedge clk_sys);
    chk("state", {5'h00, NFT_OFF}, {5'h00, state});
    chk("pins", 8'h00, {6'h00, antenna_pin_config});
    nv_protect <= 1'h1;
    do_reset();
    chk("pins", 8'h03, {6'h00, antenna_pin_config});
    chk("state", {5'h00, NFT_OFF}, {5'h00, state});
    go(0);
    @(posedge clk_sys);
    chk("state", {5'h00, NFT_LISTEN}, {5'h00, state});
    field_energy <= 1'h1;
    field_usable <= 1'h1;
    repeat (6) @(posedge clk_sys);
    chk("present", 8'h01, {7'h00, events.present});
    clr(4'h8);
    go(1);
    repeat (6) @(posedge clk_sys);
    chk("present", 8'h00, {7'h00, events.present});
    xo_running <= 1'h1;
    go(2);
    @(posedge clk_sys);
    chk("calibrating", 8'h01, {7'h00, calibrating});
    repeat (NFT_CAL_CYC + 6) @(posedge clk_sys);
    chk("state", {5'h00, NFT_OPER}, {5'h00, state});
    chk("present", 8'h01, {7'h00, events.present});
    repeat (3) begin
      lfsr_ff = lfsr_next(lfsr_ff);
      b = lfsr_ff[7:0];
      rd_u.send_byte(b);
      repeat (10) @(posedge clk_sys);
      chk("writes", 8'h01, 8'(wr_q.size()));
      if (wr_q.size() > 0) chk("rx byte", b, wr_q.pop_front());
      chk("rx done", 8'h01, {7'h00, events.rx_done});
      clr(4'h2);
    end
    lfsr_ff = lfsr_next(lfsr_ff);
    // bit 0 forced high so the reader can find the start of the byte on air
    b = {lfsr_ff[7:1], 1'h1};
    mem_rd_data <= b;
    tx_delay <= {4'h0, lfsr_ff[11:8]};
    mem_rd_last <= 1'h1;
    go(4);
    repeat (40) @(posedge clk_sys);
    chk("fetches", 8'h01, 8'(rd_cnt));
    chk("tx done", 8'h01, {7'h00, events.tx_done});
    chk("tx byte", b, rd_u.tx_cap);
    st = {5'h00, state};
    field_usable <= 1'h0;
    repeat (8) @(posedge clk_sys);
    chk("gone", 8'h01, {7'h00, events.gone});
    chk("state", st, {5'h00, state});
    field_energy <= 1'h0;
    go(3);
    go(0);
    clr(4'h4);
    field_energy <= 1'h1;
    repeat (8) @(posedge clk_sys);
    chk("gone", 8'h00, {7'h00, events.gone});
    sys_sleep <= 1'h1;
    repeat (10) @(posedge clk_sys);
    chk("wake", 8'h01, {7'h00, wake_reset});
    chk("cause", 8'h01, {7'h00, reset_cause_nf});
    sys_sleep <= 1'h0;
    field_energy <= 1'h0;
    shortcut_en <= 1'h1;
    repeat (4) @(posedge clk_sys);
    field_energy <= 1'h1;
    repeat (6) @(posedge clk_sys);
    chk("shortcut", 8'h01, {7'h00, calibrating});
    go(1);
    @(posedge clk_sys);
    chk("state", {5'h00, NFT_LISTEN}, {5'h00, state});
    do_reset();
    chk("state", {5'h00, NFT_OFF}, {5'h00, state});
    stop_test();
  end
endmodule
bind nft_tag nft_chk chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .nv_protect(nv_protect), .field_energy(field_energy),
  .sys_sleep(sys_sleep), .xo_running(xo_running), .task_bringup(task_bringup),
  .evt_clear(evt_clear), .events(events), .state(state), .wake_reset(wake_reset),
  .reset_cause_nf(reset_cause_nf), .antenna_pin_config(antenna_pin_config),
  .calibrating(calibrating)
);
`default_nettype wire
